/* status_pkg.sv */
// Shared constants and carrier types for the status and event reporting block.
package status_pkg;

    localparam int unsigned REG_W = 16;

    // Register selectors used on the command port.
    localparam logic [3:0] SEL_REF_COND = 4'h0;
    localparam logic [3:0] SEL_REF_EVT  = 4'h1;
    localparam logic [3:0] SEL_REF_EN   = 4'h2;
    localparam logic [3:0] SEL_PF_COND  = 4'h3;
    localparam logic [3:0] SEL_PF_EN    = 4'h4;
    localparam logic [3:0] SEL_PF_EVT   = 4'h5;
    localparam logic [3:0] SEL_ACT_COND = 4'h6;
    localparam logic [3:0] SEL_ACT_EN   = 4'h7;
    localparam logic [3:0] SEL_ACT_EVT  = 4'h8;

    // Implemented bits of each group; all other bits read zero.
    localparam logic [15:0] REF_VALID = 16'h001f;
    localparam logic [15:0] PF_VALID  = 16'h00ff;
    localparam logic [15:0] ACT_VALID = 16'h4109;

    // Activity bit positions.
    localparam int unsigned ACT_CAL_BIT  = 0;
    localparam int unsigned ACT_SWP_BIT  = 3;
    localparam int unsigned ACT_AVG_BIT  = 8;
    localparam int unsigned ACT_PROG_BIT = 14;

    // Summary bit positions.
    localparam int unsigned WARN_REF_BIT = 5;
    localparam int unsigned WARN_PF_BIT  = 9;
    localparam int unsigned SB_WARN_BIT  = 3;
    localparam int unsigned SB_ACT_BIT   = 7;

    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0]  SB_RESET  = 8'h00;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  sel;
        logic [15:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } rsp_s;

    typedef struct packed {
        logic calibrating;
        logic sweeping;
        logic averaging;
        logic prog_running;
    } activity_s;

endpackage

/* status_event_reporting.sv */
// Condition, event and enable registers with their summary bits.
`timescale 1ns/1ps

// Operation
// - Reference-lock events latch bits 0 to 4; other bits read zero.
// - Reading reference-lock events returns them, clears them and warning bit 5.
// - Pass/fail condition holds eight live failure bits, two per channel.
// - Reading pass/fail condition returns it without clearing.
// - Pass/fail enable mask is read/write and gates events into warning bit 9.
// - Pass/fail events latch the same eight bits; bits above 7 read zero.
// - Reading pass/fail events returns them, clears them and warning bit 9.
// - Activity condition shows calibrating, sweeping, averaging, program running.
// - Reading activity condition returns it without clearing.
// - Activity enable mask is read/write and gates events into status bit 7.
// - Activity events set when calibration, sweep, averaging or program ends.
// - Reading activity events returns them, clears them and status bit 7.
// - Reference-lock enable mask is read/write and gates events into warning bit 5.
// - Any warning summary bit set shows in status byte bit 3.
module status_event_reporting (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    // Command port
    input  wire status_pkg::cmd_s      i_cmd,
    output status_pkg::rsp_s           o_rsp,
    // Live instrument state
    input  wire logic [4:0]            i_ref_lock_state,
    input  wire logic [7:0]            i_trace_fail,
    input  wire status_pkg::activity_s i_activity,
    // Summary outputs
    output logic [15:0]                o_warning_summary,
    output logic [7:0]                 o_status_byte
);

    function automatic logic summary(input logic [15:0] ev, input logic [15:0] en);
        summary = |(ev & en);
    endfunction

    logic [15:0] ref_cond_q, ref_cond_d, pf_cond_q, pf_cond_d, act_cond_q, act_cond_d;
    logic [15:0] ref_ev_q, ref_ev_d, pf_ev_q, pf_ev_d, act_ev_q, act_ev_d;
    logic [15:0] ref_en_q, ref_en_d, pf_en_q, pf_en_d, act_en_q, act_en_d;
    logic [15:0] ref_rise, pf_rise, act_fall;
    logic [15:0] warn_d;
    logic [7:0]  sb_d;
    logic        rd, wr, clr_ref, clr_pf, clr_act;
    status_pkg::rsp_s rsp_d;

    always_comb begin
        rd = i_cmd.valid && !i_cmd.write;
        wr = i_cmd.valid && i_cmd.write;
        clr_ref = rd && (i_cmd.sel == status_pkg::SEL_REF_EVT);
        clr_pf = rd && (i_cmd.sel == status_pkg::SEL_PF_EVT);
        clr_act = rd && (i_cmd.sel == status_pkg::SEL_ACT_EVT);

        // Live conditions, placed at their documented bit positions.
        ref_cond_d = 16'(i_ref_lock_state) & status_pkg::REF_VALID;
        pf_cond_d = 16'(i_trace_fail) & status_pkg::PF_VALID;
        act_cond_d = status_pkg::REG_RESET;
        act_cond_d[status_pkg::ACT_CAL_BIT] = i_activity.calibrating;
        act_cond_d[status_pkg::ACT_SWP_BIT] = i_activity.sweeping;
        act_cond_d[status_pkg::ACT_AVG_BIT] = i_activity.averaging;
        act_cond_d[status_pkg::ACT_PROG_BIT] = i_activity.prog_running;

        // Faults latch on entry; activities latch on completion.
        ref_rise = ref_cond_d & ~ref_cond_q;
        pf_rise = pf_cond_d & ~pf_cond_q;
        act_fall = act_cond_q & ~act_cond_d;

        // A clearing read drops old bits only; new events in the same cycle survive.
        ref_ev_d = (clr_ref ? status_pkg::REG_RESET : ref_ev_q) | ref_rise;
        pf_ev_d = (clr_pf ? status_pkg::REG_RESET : pf_ev_q) | pf_rise;
        act_ev_d = (clr_act ? status_pkg::REG_RESET : act_ev_q) | act_fall;

        ref_en_d = ref_en_q;
        pf_en_d = pf_en_q;
        act_en_d = act_en_q;
        if (wr) begin
            case (i_cmd.sel)
                status_pkg::SEL_REF_EN: ref_en_d = i_cmd.wdata & status_pkg::REF_VALID;
                status_pkg::SEL_PF_EN: pf_en_d = i_cmd.wdata & status_pkg::PF_VALID;
                status_pkg::SEL_ACT_EN: act_en_d = i_cmd.wdata & status_pkg::ACT_VALID;
                default: ;
            endcase
        end

        rsp_d.valid = rd;
        rsp_d.data = status_pkg::REG_RESET;
        if (rd) begin
            case (i_cmd.sel)
                status_pkg::SEL_REF_COND: rsp_d.data = ref_cond_q;
                status_pkg::SEL_REF_EVT: rsp_d.data = ref_ev_q;
                status_pkg::SEL_REF_EN: rsp_d.data = ref_en_q;
                status_pkg::SEL_PF_COND: rsp_d.data = pf_cond_q;
                status_pkg::SEL_PF_EN: rsp_d.data = pf_en_q;
                status_pkg::SEL_PF_EVT: rsp_d.data = pf_ev_q;
                status_pkg::SEL_ACT_COND: rsp_d.data = act_cond_q;
                status_pkg::SEL_ACT_EN: rsp_d.data = act_en_q;
                status_pkg::SEL_ACT_EVT: rsp_d.data = act_ev_q;
                default: rsp_d.data = status_pkg::REG_RESET;
            endcase
        end

        warn_d = status_pkg::REG_RESET;
        warn_d[status_pkg::WARN_REF_BIT] = summary(ref_ev_q, ref_en_q);
        warn_d[status_pkg::WARN_PF_BIT] = summary(pf_ev_q, pf_en_q);
        sb_d = status_pkg::SB_RESET;
        sb_d[status_pkg::SB_WARN_BIT] = |warn_d;
        sb_d[status_pkg::SB_ACT_BIT] = summary(act_ev_q, act_en_q);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ref_cond_q <= status_pkg::REG_RESET;
            pf_cond_q <= status_pkg::REG_RESET;
            act_cond_q <= status_pkg::REG_RESET;
            ref_ev_q <= status_pkg::REG_RESET;
            pf_ev_q <= status_pkg::REG_RESET;
            act_ev_q <= status_pkg::REG_RESET;
            ref_en_q <= status_pkg::REG_RESET;
            pf_en_q <= status_pkg::REG_RESET;
            act_en_q <= status_pkg::REG_RESET;
            o_rsp <= '0;
            o_warning_summary <= status_pkg::REG_RESET;
            o_status_byte <= status_pkg::SB_RESET;
        end else begin
            ref_cond_q <= ref_cond_d;
            pf_cond_q <= pf_cond_d;
            act_cond_q <= act_cond_d;
            ref_ev_q <= ref_ev_d;
            pf_ev_q <= pf_ev_d;
            act_ev_q <= act_ev_d;
            ref_en_q <= ref_en_d;
            pf_en_q <= pf_en_d;
            act_en_q <= act_en_d;
            o_rsp <= rsp_d;
            o_warning_summary <= warn_d;
            o_status_byte <= sb_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_ref_read;
        clr_ref && (ref_rise == 16'h0000);
    endsequence
    sequence s_pf_read;
        clr_pf && (pf_rise == 16'h0000);
    endsequence
    sequence s_act_read;
        clr_act && (act_fall == 16'h0000);
    endsequence

    property p_ref_bits;
        (ref_ev_q & ~status_pkg::REF_VALID) == 16'h0000;
    endproperty
    a_ref_bits: assert property (p_ref_bits) else $error("ref event stray bit");

    property p_ref_latch;
        (ref_cond_d[2] && !ref_cond_q[2]) |=> ref_ev_q[2];
    endproperty
    a_ref_latch: assert property (p_ref_latch) else $error("ref event not latched");

    property p_ref_clear;
        s_ref_read |=> (o_rsp.data == $past(ref_ev_q)) && (ref_ev_q == 16'h0000)
            ##1 !o_warning_summary[5];
    endproperty
    a_ref_clear: assert property (p_ref_clear) else $error("ref read did not clear");

    property p_pf_cond;
        !$past(i_srst) |-> pf_cond_q == {8'h00, $past(i_trace_fail)};
    endproperty
    a_pf_cond: assert property (p_pf_cond) else $error("pass/fail condition wrong");

    property p_pf_cond_read;
        (rd && i_cmd.sel == status_pkg::SEL_PF_COND) |=>
            o_rsp.valid && (o_rsp.data == $past(pf_cond_q)) && (pf_cond_q == $past(pf_cond_d));
    endproperty
    a_pf_cond_read: assert property (p_pf_cond_read) else $error("cond read wrong");

    property p_pf_mask;
        (wr && i_cmd.sel == status_pkg::SEL_PF_EN) |=>
            pf_en_q == ($past(i_cmd.wdata) & status_pkg::PF_VALID);
    endproperty
    a_pf_mask: assert property (p_pf_mask) else $error("pass/fail mask not written");

    property p_pf_bits;
        pf_ev_q[15:8] == 8'h00;
    endproperty
    a_pf_bits: assert property (p_pf_bits) else $error("pass/fail event high bit");

    property p_pf_clear;
        s_pf_read |=> (pf_ev_q == 16'h0000) ##1 !o_warning_summary[9];
    endproperty
    a_pf_clear: assert property (p_pf_clear) else $error("pass/fail read did not clear");

    property p_act_cond;
        !$past(i_srst) |->
            (act_cond_q[status_pkg::ACT_PROG_BIT] == $past(i_activity.prog_running))
            && (act_cond_q[status_pkg::ACT_SWP_BIT] == $past(i_activity.sweeping));
    endproperty
    a_act_cond: assert property (p_act_cond) else $error("activity condition wrong");

    property p_act_cond_read;
        (rd && i_cmd.sel == status_pkg::SEL_ACT_COND) |=> o_rsp.data == $past(act_cond_q);
    endproperty
    a_act_cond_read: assert property (p_act_cond_read) else $error("activity read wrong");

    property p_act_sum;
        (act_ev_q[8] && act_en_q[8]) |=> o_status_byte[7];
    endproperty
    a_act_sum: assert property (p_act_sum) else $error("status bit 7 missing");

    property p_act_end;
        (act_cond_q[3] && !act_cond_d[3]) |=> act_ev_q[3] && !act_cond_q[3];
    endproperty
    a_act_end: assert property (p_act_end) else $error("sweep end not latched");

    property p_act_clear;
        s_act_read |=> (act_ev_q == 16'h0000) ##1 !o_status_byte[7];
    endproperty
    a_act_clear: assert property (p_act_clear) else $error("activity read did not clear");

    property p_ref_sum;
        (ref_ev_q[4] && ref_en_q[4]) |=> o_warning_summary[5] && o_status_byte[3];
    endproperty
    a_ref_sum: assert property (p_ref_sum) else $error("warning bit 5 missing");

    property p_sb_warn;
        o_status_byte[3] == (o_warning_summary != 16'h0000);
    endproperty
    a_sb_warn: assert property (p_sb_warn) else $error("status bit 3 mismatch");

    property p_set_wins;
        (clr_pf && pf_rise[1]) |=> pf_ev_q[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");

    property p_summary;
        !$past(i_srst) |->
            o_warning_summary[status_pkg::WARN_PF_BIT] == $past(|(pf_ev_q & pf_en_q));
    endproperty
    a_summary: assert property (p_summary) else $error("summary not OR of AND");

    property p_ref_summary;
        !$past(i_srst) |->
            o_warning_summary[status_pkg::WARN_REF_BIT] == $past(|(ref_ev_q & ref_en_q));
    endproperty
    a_ref_summary: assert property (p_ref_summary) else $error("warning bit 5 wrong");

    property p_act_summary;
        !$past(i_srst) |->
            o_status_byte[status_pkg::SB_ACT_BIT] == $past(|(act_ev_q & act_en_q));
    endproperty
    a_act_summary: assert property (p_act_summary) else $error("status bit 7 wrong");

    property p_reset_quiet;
        $past(i_srst) |-> !o_rsp.valid && (o_warning_summary == status_pkg::REG_RESET)
            && (o_status_byte == status_pkg::SB_RESET);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

    property p_ref_mask;
        (wr && i_cmd.sel == status_pkg::SEL_REF_EN) |=>
            ref_en_q == ($past(i_cmd.wdata) & status_pkg::REF_VALID);
    endproperty
    a_ref_mask: assert property (p_ref_mask) else $error("ref mask not written");

    property p_act_mask;
        (wr && i_cmd.sel == status_pkg::SEL_ACT_EN) |=>
            act_en_q == ($past(i_cmd.wdata) & status_pkg::ACT_VALID);
    endproperty
    a_act_mask: assert property (p_act_mask) else $error("activity mask not written");

    property p_act_more;
        !$past(i_srst) |->
            (act_cond_q[status_pkg::ACT_CAL_BIT] == $past(i_activity.calibrating))
            && (act_cond_q[status_pkg::ACT_AVG_BIT] == $past(i_activity.averaging));
    endproperty
    a_act_more: assert property (p_act_more) else $error("activity bits wrong");

    property p_act_bits;
        ((act_cond_q | act_ev_q) & ~status_pkg::ACT_VALID) == 16'h0000;
    endproperty
    a_act_bits: assert property (p_act_bits) else $error("activity stray bit");

    sequence s_ref_race;
        clr_ref && (ref_rise != 16'h0000);
    endsequence
    property p_ref_set_wins;
        s_ref_race |=> (ref_ev_q & $past(ref_rise)) == $past(ref_rise);
    endproperty
    a_ref_set_wins: assert property (p_ref_set_wins) else $error("ref event lost");

    property p_ref_hold;
        !clr_ref |=> (ref_ev_q & $past(ref_ev_q)) == $past(ref_ev_q);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("ref event dropped");

    property p_pf_hold;
        !clr_pf |=> (pf_ev_q & $past(pf_ev_q)) == $past(pf_ev_q);
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("pass/fail event dropped");

    property p_act_hold;
        !clr_act |=> (act_ev_q & $past(act_ev_q)) == $past(act_ev_q);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("activity event dropped");

    property p_rsp_pulse;
        !$past(i_srst) |-> o_rsp.valid == $past(rd);
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("read answer timing");

    property p_rsp_idle;
        !o_rsp.valid |-> o_rsp.data == status_pkg::REG_RESET;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("read data without valid");

endmodule

/* status_event_reporting_test.sv */
// Self-checking testbench for the status and event reporting block.
`timescale 1ns/1ps
module status_event_reporting_test;
    logic                  clk;
    logic                  srst;
    status_pkg::cmd_s      cmd;
    status_pkg::rsp_s      rsp;
    logic [4:0]            ref_lock_state;
    logic [7:0]            trace_fail;
    status_pkg::activity_s activity;
    logic [15:0]           warning_summary;
    logic [7:0]            status_byte;
    int                    n_errors;
    int                    num_checks;

    status_event_reporting dut_u (
        .i_clk             (clk),
        .i_srst            (srst),
        .i_cmd             (cmd),
        .o_rsp             (rsp),
        .i_ref_lock_state  (ref_lock_state),
        .i_trace_fail      (trace_fail),
        .i_activity        (activity),
        .o_warning_summary (warning_summary),
        .o_status_byte     (status_byte)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A read answers in the cycle after it is taken, for one cycle only.
    task automatic rd(input logic [3:0] s, input logic [15:0] e, input string nm);
        cmd = {1'b1, 1'b0, s, 16'h0000};
        tick(1);
        cmd.valid = 1'b0;
        chk({nm, "_valid"}, 16'h0001, {15'h0000, rsp.valid});
        chk(nm, e, rsp.data);
        tick(1);
        chk({nm, "_drop"}, 16'h0000, {15'h0000, rsp.valid});
    endtask

    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        cmd = {1'b1, 1'b1, s, d};
        tick(1);
        cmd.valid = 1'b0;
        tick(1);
    endtask

    task automatic sums(input logic [15:0] w, input logic [7:0] b);
        chk("warning_summary", w, warning_summary);
        chk("status_byte", {8'h00, b}, {8'h00, status_byte});
    endtask

    task automatic test_reset;
        sums(16'h0000, 8'h00);
        rd(status_pkg::SEL_PF_EN, 16'h0000, "pf_en_rst");
        rd(4'hf, 16'h0000, "unknown_sel");
    endtask

    task automatic test_ref;
        ref_lock_state = 5'h1f;
        tick(3);
        rd(status_pkg::SEL_REF_COND, 16'h001f, "ref_cond");
        sums(16'h0000, 8'h00);
        wr(status_pkg::SEL_REF_EN, 16'hffff);
        rd(status_pkg::SEL_REF_EN, 16'h001f, "ref_en");
        sums(16'h0020, 8'h08);
        ref_lock_state = 5'h1e;
        tick(1);
        ref_lock_state = 5'h1f;
        rd(status_pkg::SEL_REF_EVT, 16'h001f, "ref_evt");
        sums(16'h0020, 8'h08);
        rd(status_pkg::SEL_REF_EVT, 16'h0001, "ref_evt_kept");
        sums(16'h0000, 8'h00);
        rd(status_pkg::SEL_REF_EVT, 16'h0000, "ref_evt_clr");
    endtask

    task automatic test_pf;
        trace_fail = 8'h5a;
        tick(3);
        rd(status_pkg::SEL_PF_COND, 16'h005a, "pf_cond");
        rd(status_pkg::SEL_PF_COND, 16'h005a, "pf_cond_again");
        wr(status_pkg::SEL_PF_EN, 16'hff01);
        rd(status_pkg::SEL_PF_EN, 16'h0001, "pf_en");
        sums(16'h0000, 8'h00);
        wr(status_pkg::SEL_PF_EN, 16'h0002);
        sums(16'h0200, 8'h08);
        rd(status_pkg::SEL_PF_EVT, 16'h005a, "pf_evt");
        sums(16'h0000, 8'h00);
        trace_fail = 8'ha5;
        tick(3);
        rd(status_pkg::SEL_PF_EVT, 16'h00a5, "pf_evt2");
        trace_fail = 8'ha7;
        rd(status_pkg::SEL_PF_EVT, 16'h0000, "pf_evt_race");
        sums(16'h0200, 8'h08);
        rd(status_pkg::SEL_PF_EVT, 16'h0002, "pf_evt_kept");
        rd(status_pkg::SEL_PF_EVT, 16'h0000, "pf_evt_clr");
        trace_fail = 8'h00;
        tick(3);
    endtask

    task automatic test_act;
        logic [15:0] ev [4];
        ev = '{16'h4000, 16'h0100, 16'h0008, 16'h0001};
        wr(status_pkg::SEL_ACT_EN, 16'hffff);
        rd(status_pkg::SEL_ACT_EN, 16'h4109, "act_en");
        for (int i = 0; i < 4; i++) begin
            activity = 4'hf;
            tick(3);
            rd(status_pkg::SEL_ACT_COND, 16'h4109, "act_cond");
            rd(status_pkg::SEL_ACT_EVT, 16'h0000, "act_evt_none");
            activity = 4'hf ^ (4'h1 << i);
            tick(3);
            sums(16'h0000, 8'h80);
            rd(status_pkg::SEL_ACT_COND, 16'h4109 ^ ev[i], "act_cond_end");
            rd(status_pkg::SEL_ACT_EVT, ev[i], "act_evt");
            sums(16'h0000, 8'h00);
        end
        activity = 4'h0;
        tick(3);
    endtask

    task automatic results;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        n_errors = 0;
        num_checks = 0;
        srst = 1'b1;
        cmd = '0;
        ref_lock_state = 5'h00;
        trace_fail = 8'h00;
        activity = 4'h0;
        tick(5);
        srst = 1'b0;
        tick(1);
        test_reset();
        test_ref();
        test_pf();
        test_act();
        results();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
